// file: common/tsfp_map.svh
// Register indexes, field positions, reset values and state codes.
// Assumes inclusion by bare name from the sequencer and status port design files.
`ifndef TSFP_MAP_SVH
`define TSFP_MAP_SVH

// Register indexes; the APB byte address is four times the index.
`define TSFP_IDX_STATUS2 8'h08
`define TSFP_IDX_DATA 8'h09
`define TSFP_IDX_LEVEL 8'h0A
`define TSFP_IDX_FRAME 8'h0D
`define TSFP_IDX_CTRL 8'h10
`define TSFP_IDX_TXGUARD 8'h11
`define TSFP_IDX_RXGUARD 8'h12
`define TSFP_IDX_IRQSTAT 8'h13
`define TSFP_IDX_IRQMASK 8'h14

// Secondary status field positions.
`define TSFP_ST_TEMPCLR 7
`define TSFP_ST_FAST 6
`define TSFP_ST_PEER 4
`define TSFP_ST_CIPHER 3

// Level register, frame control and control register fields.
`define TSFP_LVL_FLUSH 7
`define TSFP_FRM_LAUNCH 7
`define TSFP_CTL_TXFIELD 0
`define TSFP_CTL_RXFIELD 1

// Interrupt status bit positions.
`define TSFP_IRQ_TEMP 0
`define TSFP_IRQ_PEER 1
`define TSFP_IRQ_CIPHER 2
`define TSFP_IRQ_OVF 3

// Reset values.
`define TSFP_RST_BYTE 8'h00
`define TSFP_RST_GUARD 8'h04
`define TSFP_RST_IRQ 4'h0

// Buffer size.
`define TSFP_BUF_DEPTH 7'h40

// Transceiver state codes as seen by software.
`define TSFP_CODE_IDLE 3'h0
`define TSFP_CODE_LAUNCH 3'h1
`define TSFP_CODE_TX_WAIT_STATE 3'h2
`define TSFP_CODE_SEND 3'h3
`define TSFP_CODE_RX_WAIT_STATE 3'h4
`define TSFP_CODE_WAITDATA 3'h5
`define TSFP_CODE_RECV 3'h6

`endif

// file: common/tsfp_pkg.sv
// Types shared by the transceiver status and buffer port block.
// Assumes nothing beyond a SystemVerilog compiler.
package tsfp_pkg;

	// Combined transmitter and receiver sequencer states.
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_LAUNCH,
		ST_TX_WAIT_STATE,
		ST_SEND,
		ST_RX_WAIT_STATE,
		ST_WAITDATA,
		ST_RECV
	} tsfp_state_type;

endpackage : tsfp_pkg

// file: core/tsfp_buf_mem.sv
// The 64 x 8 buffer storage with one write and one read port.
// Assumes the caller keeps its own pointers; read data are registered.
`timescale 1ns/10ps
module tsfp_buf_mem (
	input wire logic clk, // Device clock.
	input wire logic we, // Write strobe.
	input wire logic [5:0] waddr, // Write address.
	input wire logic [7:0] wdata, // Write data.
	input wire logic [5:0] raddr, // Read address for the next cycle.
	output logic [7:0] rdata // Registered read data.
);

	// Storage array; no reset, contents are undefined at power up.
	logic [7:0] mem [0:63];

	// Write port.
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// Read port with write-through, so a byte pushed into an empty
	// buffer is visible at its head on the very next cycle.
	always_ff @(posedge clk) begin
		if (we && (waddr == raddr)) begin
			rdata <= wdata;
		end else begin
			rdata <= mem[raddr];
		end
	end

endmodule : tsfp_buf_mem

// file: core/tsfp_xcvr_fsm.sv
// Combined transmit and receive sequencer reporting its state code.
// Assumes same-clock control inputs; field input already synchronised.
`timescale 1ns/10ps
`include "tsfp_map.svh"
module tsfp_xcvr_fsm (
	input wire logic clk, // Device clock.
	input wire logic rstn, // Asynchronous reset, active low.
	input wire logic transceiveRun, // Transceive command active.
	input wire logic launch, // Transmit launch pulse from software.
	input wire logic txWaitForField, // Hold transmit wait until field.
	input wire logic rxWaitForField, // Hold receive wait until field.
	input wire logic fieldOn, // External RF field present.
	input wire logic [7:0] txGuard, // Least transmit wait in cycles.
	input wire logic [7:0] rxGuard, // Least receive wait in cycles.
	input wire logic txDone, // Last transmit bit sent.
	input wire logic rxStart, // Receive data begin.
	input wire logic rxDone, // Receive frame end.
	output logic [2:0] stateCode // Registered state code.
);

	tsfp_pkg::tsfp_state_type state_r; // Current state.
	tsfp_pkg::tsfp_state_type state_nxt; // Next state.
	logic [7:0] guardCnt_r; // Cycles spent in a wait state.
	logic [2:0] code_nxt; // Code for the next state.
	logic txGo; // Transmit wait may end.
	logic rxGo; // Receive wait may end.

	// Both waits last at least the guard time; the field is only
	// demanded when the matching wait bit is set.
	assign txGo = (guardCnt_r >= txGuard) && (!txWaitForField || fieldOn);
	assign rxGo = (guardCnt_r >= rxGuard) && (!rxWaitForField || fieldOn);

	// Next state; leaving the transceive command always ends in idle.
	always_comb begin
		state_nxt = state_r;
		if (!transceiveRun) begin
			state_nxt = tsfp_pkg::ST_IDLE;
		end else begin
			unique case (state_r)
				tsfp_pkg::ST_IDLE: state_nxt = tsfp_pkg::ST_LAUNCH;
				tsfp_pkg::ST_LAUNCH: if (launch) state_nxt = tsfp_pkg::ST_TX_WAIT_STATE;
				tsfp_pkg::ST_TX_WAIT_STATE: if (txGo) state_nxt = tsfp_pkg::ST_SEND;
				tsfp_pkg::ST_SEND: if (txDone) state_nxt = tsfp_pkg::ST_RX_WAIT_STATE;
				tsfp_pkg::ST_RX_WAIT_STATE: if (rxGo) state_nxt = tsfp_pkg::ST_WAITDATA;
				tsfp_pkg::ST_WAITDATA: if (rxStart) state_nxt = tsfp_pkg::ST_RECV;
				tsfp_pkg::ST_RECV: if (rxDone) state_nxt = tsfp_pkg::ST_LAUNCH;
				default: state_nxt = tsfp_pkg::ST_IDLE;
			endcase
		end
	end

	// Map each state to its code; 111 can never be produced.
	always_comb begin
		unique case (state_nxt)
			tsfp_pkg::ST_IDLE: code_nxt = `TSFP_CODE_IDLE;
			tsfp_pkg::ST_LAUNCH: code_nxt = `TSFP_CODE_LAUNCH;
			tsfp_pkg::ST_TX_WAIT_STATE: code_nxt = `TSFP_CODE_TX_WAIT_STATE;
			tsfp_pkg::ST_SEND: code_nxt = `TSFP_CODE_SEND;
			tsfp_pkg::ST_RX_WAIT_STATE: code_nxt = `TSFP_CODE_RX_WAIT_STATE;
			tsfp_pkg::ST_WAITDATA: code_nxt = `TSFP_CODE_WAITDATA;
			tsfp_pkg::ST_RECV: code_nxt = `TSFP_CODE_RECV;
			default: code_nxt = `TSFP_CODE_IDLE;
		endcase
	end

	// State and code registers.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_r <= tsfp_pkg::ST_IDLE;
			stateCode <= `TSFP_CODE_IDLE;
		end else begin
			state_r <= state_nxt;
			stateCode <= code_nxt;
		end
	end

	// Guard counter restarts on every state change and saturates.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			guardCnt_r <= 8'h00;
		end else if (state_nxt != state_r) begin
			guardCnt_r <= 8'h00;
		end else if (guardCnt_r != 8'hFF) begin
			guardCnt_r <= guardCnt_r + 8'h01;
		end
	end

endmodule : tsfp_xcvr_fsm

// file: core/tsfp_status_port.sv
// Secondary status register and byte port of the 64-byte buffer.
// Assumes an APB3 master on clk; temperature and field come from pins.
`timescale 1ns/10ps
`include "tsfp_map.svh"
module tsfp_status_port (
	input wire logic clk, // Device clock, 50 MHz.
	input wire logic rstn, // Asynchronous reset, active low.
	input wire logic [11:0] paddr, // APB byte address.
	input wire logic psel, // APB select.
	input wire logic penable, // APB access phase.
	input wire logic pwrite, // APB direction, high for write.
	input wire logic [31:0] pwdata, // APB write data.
	output logic [31:0] prdata, // APB read data.
	output logic pready, // APB ready.
	output logic pslverr, // APB error for unmapped access.
	input wire logic tempHighPin, // Die above alarm limit, async pin.
	input wire logic fieldPin, // External RF field present, async pin.
	input wire logic readerMode, // Reader/writer mode selected.
	input wire logic passiveMode, // Passive communication mode.
	input wire logic autoCollRun, // Automatic anticollision running.
	input wire logic peerAnswered, // Select or poll answered, pulse.
	input wire logic authOk, // Card authentication succeeded, pulse.
	input wire logic transceiveRun, // Transceive command active.
	input wire logic txDone, // Transmit frame finished, pulse.
	input wire logic rxStart, // Receive data started, pulse.
	input wire logic rxDone, // Receive frame finished, pulse.
	input wire logic txPop, // Serial side takes a byte, pulse.
	input wire logic rxPush, // Serial side stores a byte, pulse.
	input wire logic [7:0] rxByte, // Received byte to store.
	output logic [7:0] txByte, // Byte taken for transmission.
	output logic filterFast, // Host input filter in fast setting.
	output logic cipherOn, // Card cipher active.
	output logic peerSelected, // Peer-selected flag.
	output logic tempErr, // Latched temperature error.
	output logic bufOverflow, // Buffer overflow error.
	output logic [2:0] xcvrState, // Sequencer state code.
	output logic irq // Interrupt, high while an unmasked event.
);

	// Pin synchronisers; the first stages feed only the second.
	logic tempMeta_r; // First stage, temperature.
	logic tempSync_r; // Second stage, temperature.
	logic fieldMeta_r; // First stage, field.
	logic fieldSync_r; // Second stage, field.
	logic fieldDly_r; // Field delayed once for edge detection.

	// Status register bits held here.
	logic tempClear_r; // Temperature clear bit as written.
	logic filterFast_r; // Filter force bit.
	logic peer_r; // Peer-selected flag.
	logic cipher_r; // Cipher-active flag.
	logic tempErr_r; // Latched temperature error.

	// Control registers.
	logic [1:0] ctrl_r; // Wait-for-field bits.
	logic [7:0] txGuard_r; // Transmit guard time in cycles.
	logic [7:0] rxGuard_r; // Receive guard time in cycles.
	logic [3:0] irqStat_r; // Sticky event bits.
	logic [3:0] irqMask_r; // Event enables.
	logic [3:0] irqStat_nxt; // Next event bits.
	logic [3:0] irqEvt; // Events this cycle.

	// Buffer state.
	logic [5:0] wrPtr_r; // Next slot to write.
	logic [5:0] rdPtr_r; // Oldest stored slot.
	logic [5:0] rdPtr_nxt; // Read pointer for the next cycle.
	logic [6:0] count_r; // Fill count, 0 to 64.
	logic ovf_r; // Overflow error.
	logic [7:0] bufHead; // Byte at the read pointer.

	// Bus decode.
	logic access; // First access cycle of a transfer.
	logic [7:0] idx; // Register index from the address.
	logic hit; // Address names a register.
	logic wrStb; // Register write this cycle.
	logic rdStb; // Register read this cycle.
	logic [7:0] rdMux; // Read data for the addressed register.

	// Buffer strobes.
	logic hostPush; // Software writes the data port.
	logic hostPop; // Software reads the data port.
	logic serPop; // Serial side takes a byte.
	logic doPush; // A byte is stored.
	logic doPop; // A byte is removed.
	logic full; // Buffer holds 64 bytes.
	logic flush; // Flush written.
	logic [7:0] pushData; // Byte being stored.

	// Event conditions.
	logic fieldFell; // Field just switched off.
	logic peerSet; // Peer flag set condition.
	logic cipherSet; // Cipher flag set condition.
	logic tempClrOk; // Clear of the temperature error allowed.
	logic launch; // Transmit launch written.
	logic [2:0] stateCode; // Code from the sequencer.

	// Two flip-flops on each pin before anything looks at it.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tempMeta_r <= 1'b0;
			tempSync_r <= 1'b0;
			fieldMeta_r <= 1'b0;
			fieldSync_r <= 1'b0;
			fieldDly_r <= 1'b0;
		end else begin
			tempMeta_r <= tempHighPin;
			tempSync_r <= tempMeta_r;
			fieldMeta_r <= fieldPin;
			fieldSync_r <= fieldMeta_r;
			fieldDly_r <= fieldSync_r;
		end
	end

	// A transfer is acted on once, in the cycle before pready rises,
	// so that read data and pready appear together one cycle later.
	assign access = psel && penable && !pready;
	assign idx = paddr[9:2];
	assign wrStb = access && pwrite && hit;
	assign rdStb = access && !pwrite && hit;

	// Address decode; misaligned or high addresses are unmapped.
	always_comb begin
		hit = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
		case (idx)
			`TSFP_IDX_STATUS2, `TSFP_IDX_DATA, `TSFP_IDX_LEVEL,
			`TSFP_IDX_FRAME, `TSFP_IDX_CTRL, `TSFP_IDX_TXGUARD,
			`TSFP_IDX_RXGUARD, `TSFP_IDX_IRQSTAT,
			`TSFP_IDX_IRQMASK: hit = hit;
			default: hit = 1'b0;
		endcase
	end

	// Read data selection; reserved and write-only bits read zero.
	always_comb begin
		rdMux = 8'h00;
		case (idx)
			`TSFP_IDX_STATUS2: begin
				rdMux = {tempClear_r, filterFast_r, 1'b0, peer_r,
					cipher_r, stateCode};
			end
			`TSFP_IDX_DATA: rdMux = bufHead;
			`TSFP_IDX_LEVEL: rdMux = {1'b0, count_r};
			`TSFP_IDX_CTRL: rdMux = {6'h00, ctrl_r};
			`TSFP_IDX_TXGUARD: rdMux = txGuard_r;
			`TSFP_IDX_RXGUARD: rdMux = rxGuard_r;
			`TSFP_IDX_IRQSTAT: rdMux = {4'h0, irqStat_r};
			`TSFP_IDX_IRQMASK: rdMux = {4'h0, irqMask_r};
			default: rdMux = 8'h00;
		endcase
	end

	// APB answer: one wait state, then data, ready and error together.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= access;
			pslverr <= access && !hit;
			if (rdStb) begin
				prdata <= {24'h000000, rdMux};
			end
		end
	end

	// Software writes that steer the block.
	assign launch = wrStb && (idx == `TSFP_IDX_FRAME) &&
		pwdata[`TSFP_FRM_LAUNCH];
	assign flush = wrStb && (idx == `TSFP_IDX_LEVEL) &&
		pwdata[`TSFP_LVL_FLUSH];

	// Status register software bits.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tempClear_r <= 1'b0;
			filterFast_r <= 1'b0;
		end else if (wrStb && (idx == `TSFP_IDX_STATUS2)) begin
			tempClear_r <= pwdata[`TSFP_ST_TEMPCLR];
			filterFast_r <= pwdata[`TSFP_ST_FAST];
		end
	end

	// The filter output follows the force bit; at zero the filter logic
	// outside uses whatever protocol speed it detects itself.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			filterFast <= 1'b0;
		end else begin
			filterFast <= filterFast_r;
		end
	end

	// Temperature error: a clear is honoured only once the die has
	// cooled, so a hot part cannot be talked out of its alarm.
	assign tempClrOk = wrStb && (idx == `TSFP_IDX_STATUS2) &&
		pwdata[`TSFP_ST_TEMPCLR] && !tempSync_r;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tempErr_r <= 1'b0;
		end else if (tempSync_r) begin
			tempErr_r <= 1'b1;
		end else if (tempClrOk) begin
			tempErr_r <= 1'b0;
		end
	end

	// Peer flag; losing the field means the peer is gone, so the clear
	// takes precedence over a set in the same cycle.
	assign fieldFell = fieldDly_r && !fieldSync_r;
	assign peerSet = peerAnswered && autoCollRun && passiveMode;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			peer_r <= 1'b0;
		end else if (fieldFell) begin
			peer_r <= 1'b0;
		end else if (peerSet) begin
			peer_r <= 1'b1;
		end
	end

	// Cipher flag: hardware only sets it, software clears it by
	// writing zero; a set in the same cycle wins.
	assign cipherSet = authOk && readerMode;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cipher_r <= 1'b0;
		end else if (cipherSet) begin
			cipher_r <= 1'b1;
		end else if (wrStb && (idx == `TSFP_IDX_STATUS2) &&
			!pwdata[`TSFP_ST_CIPHER]) begin
			cipher_r <= 1'b0;
		end
	end

	// Control registers.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_r <= 2'h0;
			txGuard_r <= `TSFP_RST_GUARD;
			rxGuard_r <= `TSFP_RST_GUARD;
			irqMask_r <= `TSFP_RST_IRQ;
		end else if (wrStb) begin
			if (idx == `TSFP_IDX_CTRL) begin
				ctrl_r <= pwdata[1:0];
			end
			if (idx == `TSFP_IDX_TXGUARD) begin
				txGuard_r <= pwdata[7:0];
			end
			if (idx == `TSFP_IDX_RXGUARD) begin
				rxGuard_r <= pwdata[7:0];
			end
			if (idx == `TSFP_IDX_IRQMASK) begin
				irqMask_r <= pwdata[3:0];
			end
		end
	end

	// Buffer control. Software has priority; a serial store that meets a software write,
	// or a serial take that meets a software read, in the same cycle is dropped, a known limitation.
	assign full = (count_r == `TSFP_BUF_DEPTH);
	assign hostPush = wrStb && (idx == `TSFP_IDX_DATA);
	assign hostPop = rdStb && (idx == `TSFP_IDX_DATA) &&
		(count_r != 7'h00);
	assign serPop = txPop && !hostPop && (count_r != 7'h00);
	assign pushData = hostPush ? pwdata[7:0] : rxByte;
	assign doPush = (hostPush || rxPush) && !full && !flush;
	assign doPop = (hostPop || serPop) && !flush;

	// Read pointer one cycle ahead, so the memory head is always current.
	always_comb begin
		if (flush) begin
			rdPtr_nxt = 6'h00;
		end else if (doPop) begin
			rdPtr_nxt = rdPtr_r + 6'h01;
		end else begin
			rdPtr_nxt = rdPtr_r;
		end
	end

	// Pointers, fill count and overflow error.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wrPtr_r <= 6'h00;
			rdPtr_r <= 6'h00;
			count_r <= 7'h00;
			ovf_r <= 1'b0;
		end else if (flush) begin
			wrPtr_r <= 6'h00;
			rdPtr_r <= 6'h00;
			count_r <= 7'h00;
			ovf_r <= 1'b0;
		end else begin
			rdPtr_r <= rdPtr_nxt;
			if (doPush) begin
				wrPtr_r <= wrPtr_r + 6'h01;
			end
			if (doPush && !doPop) begin
				count_r <= count_r + 7'h01;
			end else if (doPop && !doPush) begin
				count_r <= count_r - 7'h01;
			end
			if ((hostPush || rxPush) && full) begin
				ovf_r <= 1'b1;
			end
		end
	end

	// Byte handed to the transmitter.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			txByte <= 8'h00;
		end else if (serPop) begin
			txByte <= bufHead;
		end
	end

	// Buffer storage.
	tsfp_buf_mem u_mem (
		.clk(clk),
		.we(doPush),
		.waddr(wrPtr_r),
		.wdata(pushData),
		.raddr(rdPtr_nxt),
		.rdata(bufHead)
	);

	// Transceiver sequencer.
	tsfp_xcvr_fsm u_fsm (
		.clk(clk),
		.rstn(rstn),
		.transceiveRun(transceiveRun),
		.launch(launch),
		.txWaitForField(ctrl_r[`TSFP_CTL_TXFIELD]),
		.rxWaitForField(ctrl_r[`TSFP_CTL_RXFIELD]),
		.fieldOn(fieldSync_r),
		.txGuard(txGuard_r),
		.rxGuard(rxGuard_r),
		.txDone(txDone),
		.rxStart(rxStart),
		.rxDone(rxDone),
		.stateCode(stateCode)
	);

	// Interrupt events: new set of each flag, and any overflow attempt.
	always_comb begin
		irqEvt = 4'h0;
		irqEvt[`TSFP_IRQ_TEMP] = tempSync_r && !tempErr_r;
		irqEvt[`TSFP_IRQ_PEER] = peerSet && !fieldFell && !peer_r;
		irqEvt[`TSFP_IRQ_CIPHER] = cipherSet && !cipher_r;
		irqEvt[`TSFP_IRQ_OVF] = (hostPush || rxPush) && full && !flush;
	end

	// Sticky status, cleared by writing one; a new event wins.
	always_comb begin
		irqStat_nxt = irqStat_r;
		if (wrStb && (idx == `TSFP_IDX_IRQSTAT)) begin
			irqStat_nxt = irqStat_r & ~pwdata[3:0];
		end
		irqStat_nxt = irqStat_nxt | irqEvt;
	end

	// Interrupt status and level output.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			irqStat_r <= `TSFP_RST_IRQ;
			irq <= 1'b0;
		end else begin
			irqStat_r <= irqStat_nxt;
			irq <= |(irqStat_nxt & irqMask_r);
		end
	end

	// Flag outputs, each from its own flip-flop.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cipherOn <= 1'b0;
			peerSelected <= 1'b0;
			tempErr <= 1'b0;
			bufOverflow <= 1'b0;
			xcvrState <= `TSFP_CODE_IDLE;
		end else begin
			cipherOn <= cipher_r;
			peerSelected <= peer_r;
			tempErr <= tempErr_r;
			bufOverflow <= ovf_r;
			xcvrState <= stateCode;
		end
	end

endmodule : tsfp_status_port

// file: dv/tsfp_props.sv
// Port checker for the status and buffer port block.
// Assumes a bind onto tsfp_status_port; one clock domain.
`timescale 1ns/10ps
module tsfp_props (
	input wire logic clk, // Device clock.
	input wire logic rstn, // Reset, active low.
	input wire logic psel, // APB select.
	input wire logic penable, // APB access.
	input wire logic pwrite, // APB direction.
	input wire logic pready, // APB ready.
	input wire logic pslverr, // APB error.
	input wire logic [31:0] prdata, // APB read data.
	input wire logic authOk, // Authentication pulse.
	input wire logic autoCollRun, // Anticollision running.
	input wire logic passiveMode, // Passive mode.
	input wire logic transceiveRun, // Transceive running.
	input wire logic cipherOn, // Cipher flag.
	input wire logic peerSelected, // Peer flag.
	input wire logic [2:0] xcvrState // State code.
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	// Handshake shape: one wait state, then a single pulse.
	ready_wait_a: assert property (psel && penable && !pready
		|=> pready) else $error("ready not one cycle after access");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	err_with_ready_a: assert property (pslverr |-> pready)
		else $error("error without ready");
	upper_zero_a: assert property (prdata[31:8] == 24'h0)
		else $error("read data upper bits not zero");
	// Flags move only for their documented causes.
	peer_set_ctx_a: assert property ($rose(peerSelected)
		|-> $past(autoCollRun, 2) && $past(passiveMode, 2))
		else $error("peer flag set outside passive anticollision");
	cipher_set_a: assert property ($rose(cipherOn)
		|-> $past(authOk, 2)) else $error("cipher set without auth");
	cipher_clear_a: assert property ($fell(cipherOn)
		|-> $past(psel, 2) && $past(pwrite, 2))
		else $error("cipher cleared without software write");
	// The state code never shows the unused value and idles when off.
	no_code7_a: assert property (xcvrState != 3'h7)
		else $error("unused state code reported");
	idle_off_a: assert property (!transceiveRun [*4]
		|-> xcvrState == 3'h0) else $error("not idle when stopped");
	// Guard 4 means at least five cycles in transmit wait.
	tx_guard_a: assert property (xcvrState == 3'h3 &&
		$past(xcvrState) == 3'h2 |-> $past(xcvrState, 5) == 3'h2)
		else $error("transmit wait shorter than guard");
endmodule : tsfp_props

// file: dv/tsfp_serial_model.sv
// Serial-side partner: stores received bytes, takes transmit bytes.
// Assumes the bench calls its tasks between host data-port accesses.
`timescale 1ns/10ps
module tsfp_serial_model (
	input wire logic clk, // Device clock.
	output logic txPop, // Take one transmit byte.
	output logic rxPush, // Store one received byte.
	output logic [7:0] rxByte // Received byte.
);
	initial begin
		txPop = 1'b0;
		rxPush = 1'b0;
		rxByte = 8'hA5;
	end
	// After a push the line shows the inverse, so stale data never match.
	task automatic push(input logic [7:0] b);
		@(posedge clk);
		rxPush <= 1'b1;
		rxByte <= b;
		@(posedge clk);
		rxPush <= 1'b0;
		rxByte <= ~b;
	endtask : push
	// The popped byte shows on txByte from the next cycle.
	task automatic pop();
		@(posedge clk);
		txPop <= 1'b1;
		@(posedge clk);
		txPop <= 1'b0;
	endtask : pop
endmodule : tsfp_serial_model

// file: dv/tsfp_status_port_tb.sv
// Self-checking bench for the status and buffer port block.
// Assumes the design, serial model and checker are compiled first.
`timescale 1ns/10ps
module tsfp_status_port_tb;
	localparam logic [11:0] aSt = 12'h020, aDat = 12'h024, aLvl = 12'h028;
	localparam logic [11:0] aFrm = 12'h034, aCtl = 12'h040;
	localparam logic [11:0] aTxg = 12'h044, aIst = 12'h04C, aMsk = 12'h050;
	logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, tempHigh = 1'b0, field = 1'b1, rdr = 1'b1;
	logic pasv = 1'b0, acoll = 1'b0, peerAns = 1'b0, auth = 1'b0;
	logic trun = 1'b0, txDone = 1'b0, rxStart = 1'b0, rxDone = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, txPop, rxPush, filterFast, cipherOn, irq;
	logic peerSelected, tempErr, bufOverflow;
	logic [7:0] rxByte, txByte, d [64];
	logic [2:0] xcvrState;
	logic [32:0] q [$], ex; // Expected {error, data} per transfer.
	int n_errors = 0, tests_run = 0, i;
	always #10 clk = ~clk;
	tsfp_status_port u_dut (.clk(clk), .rstn(rstn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.tempHighPin(tempHigh), .fieldPin(field), .readerMode(rdr),
		.passiveMode(pasv), .autoCollRun(acoll), .peerAnswered(peerAns),
		.authOk(auth), .transceiveRun(trun), .txDone(txDone),
		.rxStart(rxStart), .rxDone(rxDone), .txPop(txPop),
		.rxPush(rxPush), .rxByte(rxByte), .txByte(txByte),
		.filterFast(filterFast), .cipherOn(cipherOn),
		.peerSelected(peerSelected), .tempErr(tempErr),
		.bufOverflow(bufOverflow), .xcvrState(xcvrState), .irq(irq));
	tsfp_serial_model u_ser (.clk(clk), .txPop(txPop), .rxPush(rxPush),
		.rxByte(rxByte));
	task automatic chk(input string nm, input logic [31:0] s, e);
		tests_run++;
		if (s !== e) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test
	// One APB transfer; the expectation goes to the queue.
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [7:0] v, input logic [32:0] e);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, v};
		q.push_back(e);
		@(posedge clk);
		penable <= 1'b1;
		for (k = 0; k < 20 && pready !== 1'b1; k++) @(posedge clk);
		if (k == 20) begin
			n_errors++;
			end_of_test();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [7:0] v);
		apb(1'b1, a, v, 33'h0);
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		apb(1'b0, a, 8'h0, {25'h0, e});
	endtask : rd
	task automatic waitst(input logic [2:0] v);
		int k;
		for (k = 0; k < 50 && xcvrState !== v; k++) @(posedge clk);
		chk("xcvrState", xcvrState, v);
		if (k == 50) end_of_test();
	endtask : waitst
	// Each completed transfer retires the oldest expectation.
	always @(posedge clk) begin
		if (pready === 1'b1 && q.size() > 0) begin
			ex = q.pop_front();
			chk("pslverr", pslverr, ex[32]);
			if (!pwrite && !ex[32]) chk("prdata", prdata, ex[31:0]);
		end
	end
	initial begin
		void'($urandom(32'hCA90));
		for (i = 0; i < 64; i++) d[i] = $urandom;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		rd(aSt, 8'h00);
		rd(aTxg, 8'h04);
		wr(aSt, 8'h60);
		rd(aSt, 8'h40);
		chk("filterFast", filterFast, 1'b1);
		wr(aSt, 8'h00);
		apb(1'b0, 12'h3FC, 8'h0, {1'b1, 32'h0});
		$display("done: registers");
		for (i = 0; i < 65; i++) wr(aDat, d[i % 64]);
		@(posedge clk);
		chk("bufOverflow", bufOverflow, 1'b1);
		rd(aLvl, 8'h40);
		rd(aIst, 8'h08);
		wr(aMsk, 8'h08);
		repeat (2) @(posedge clk);
		chk("irq", irq, 1'b1);
		wr(aIst, 8'h08);
		repeat (2) @(posedge clk);
		chk("irq", irq, 1'b0);
		for (i = 0; i < 32; i++) rd(aDat, d[i]);
		rd(aLvl, 8'h20);
		wr(aLvl, 8'h80);
		rd(aLvl, 8'h00);
		chk("bufOverflow", bufOverflow, 1'b0);
		$display("done: buffer");
		for (i = 0; i < 3; i++) u_ser.push(d[i]);
		for (i = 0; i < 3; i++) rd(aDat, d[i]);
		wr(aDat, d[5]);
		wr(aDat, d[6]);
		for (i = 5; i < 7; i++) begin
			u_ser.pop();
			@(posedge clk);
			chk("txByte", txByte, d[i]);
		end
		$display("done: serial");
		pasv <= 1'b1;
		peerAns <= 1'b1;
		@(posedge clk);
		peerAns <= 1'b0;
		rd(aSt, 8'h00);
		acoll <= 1'b1;
		repeat (2) @(posedge clk);
		peerAns <= 1'b1;
		@(posedge clk);
		peerAns <= 1'b0;
		rd(aSt, 8'h10);
		chk("peerSelected", peerSelected, 1'b1);
		acoll <= 1'b0;
		field <= 1'b0;
		repeat (6) @(posedge clk);
		chk("peerSelected", peerSelected, 1'b0);
		for (i = 0; i < 2; i++) begin
			rdr <= i[0];
			auth <= 1'b1;
			@(posedge clk);
			auth <= 1'b0;
			rd(aSt, {4'h0, i[0], 3'h0});
		end
		chk("cipherOn", cipherOn, 1'b1);
		wr(aSt, 8'h00);
		repeat (2) @(posedge clk);
		chk("cipherOn", cipherOn, 1'b0);
		tempHigh <= 1'b1;
		repeat (5) @(posedge clk);
		wr(aSt, 8'h80);
		repeat (2) @(posedge clk);
		chk("tempErr", tempErr, 1'b1);
		tempHigh <= 1'b0;
		repeat (5) @(posedge clk);
		wr(aSt, 8'h80);
		repeat (2) @(posedge clk);
		chk("tempErr", tempErr, 1'b0);
		wr(aSt, 8'h00);
		rd(aIst, 8'h07);
		$display("done: flags");
		trun <= 1'b1;
		waitst(3'h1);
		rd(aSt, 8'h01);
		wr(aCtl, 8'h03);
		wr(aFrm, 8'h80);
		repeat (20) @(posedge clk);
		chk("xcvrState", xcvrState, 3'h2);
		field <= 1'b1;
		waitst(3'h3);
		field <= 1'b0;
		txDone <= 1'b1;
		@(posedge clk);
		txDone <= 1'b0;
		waitst(3'h4);
		repeat (20) @(posedge clk);
		chk("xcvrState", xcvrState, 3'h4);
		field <= 1'b1;
		waitst(3'h5);
		rxStart <= 1'b1;
		@(posedge clk);
		rxStart <= 1'b0;
		waitst(3'h6);
		rxDone <= 1'b1;
		@(posedge clk);
		rxDone <= 1'b0;
		waitst(3'h1);
		trun <= 1'b0;
		waitst(3'h0);
		$display("done: sequencer");
		end_of_test();
	end
endmodule : tsfp_status_port_tb
bind tsfp_status_port tsfp_props u_props (.clk(clk), .rstn(rstn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready),
	.pslverr(pslverr), .prdata(prdata), .authOk(authOk),
	.autoCollRun(autoCollRun), .passiveMode(passiveMode),
	.transceiveRun(transceiveRun), .cipherOn(cipherOn),
	.peerSelected(peerSelected), .xcvrState(xcvrState));
